// [design/ccp_unit.sv]
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module ccp_unit (
  input wire logic mclk, // Core clock, 10 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB byte address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic hreadyout, // AHB ready out
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response
  input wire logic [15:0] timebase_one_counter, // Timebase one count
  output logic timebase_one_reset, // Pulse: clear timebase one
  input wire logic adc_enabled, // Converter is switched on
  output logic adc_start, // Pulse: start a conversion
  input wire logic [9:0] timebase_two_count, // PWM timebase count
  input wire logic timebase_two_period, // Pulse: PWM period end
  input wire logic pin_route_select, // Config bit 12: 1 = pin three
  input wire logic port_b_pin_two_in, // Pin two level
  output logic port_b_pin_two_out, // Pin two drive value
  output logic port_b_pin_two_oe, // Pin two driven
  input wire logic port_b_pin_three_in, // Pin three level
  output logic port_b_pin_three_out, // Pin three drive value
  output logic port_b_pin_three_oe, // Pin three driven
  output logic irq // Level interrupt
);

  typedef struct packed {
    ccp_pkg::unit_state_t state;
    logic [ccp_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [15:0] value;
    logic [ccp_pkg::NUM_EVENTS-1:0] status;
    logic [ccp_pkg::NUM_EVENTS-1:0] irq_en;
    logic pin;
    logic pin_prev;
    logic match_prev;
    logic [9:0] duty;
    logic tmr_reset;
    logic adc_go;
  } core_t;

  core_t q, d;
  ccp_reg_if rif ();

  logic [3:0] mode;
  logic pin_in;
  logic match;
  logic hit;
  logic unit_ev;
  logic period_ev;
  logic capture_edge;
  logic drive;

  ccp_ahb_port u_port (
    .mclk(mclk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .rif(rif)
  );

  always_comb begin
    mode = q.ctrl[ccp_pkg::CTRL_MODE_MSB:ccp_pkg::CTRL_MODE_LSB];
    pin_in = pin_route_select ? port_b_pin_three_in : port_b_pin_two_in;
    match = timebase_one_counter == q.value;
    hit = match & !q.match_prev;
    capture_edge = pin_in & !q.pin_prev;
    unit_ev = 1'b0;
    period_ev = 1'b0;
    d = q;
    d.tmr_reset = 1'b0;
    d.adc_go = 1'b0;
    d.pin_prev = pin_in;
    d.match_prev = match;

    // Register writes first, so hardware events below override them
    if (rif.wr) begin
      unique case (rif.idx)
        ccp_pkg::IDX_VALUE_LOW: d.value[7:0] = rif.wdata;
        ccp_pkg::IDX_VALUE_HIGH: d.value[15:8] = rif.wdata;
        ccp_pkg::IDX_CONTROL: d.ctrl = rif.wdata[5:0];
        ccp_pkg::IDX_IRQ_ENABLE: d.irq_en = rif.wdata[1:0];
        ccp_pkg::IDX_IRQ_CLEAR: d.status = q.status & ~rif.wdata[1:0];
        default: ;
      endcase
    end

    unique case (q.state)
      ccp_pkg::ST_OFF: begin
        d.pin = 1'b0;
        d.duty = '0;
      end
      ccp_pkg::ST_CAPTURE: begin
        // A capture beats a software write to the value in the same cycle
        if (capture_edge) begin
          d.value = timebase_one_counter;
          unit_ev = 1'b1;
        end
      end
      ccp_pkg::ST_COMPARE: begin
        // Edge of the match, so a stalled timebase flags only once
        if (hit) begin
          unit_ev = 1'b1;
          if (mode == ccp_pkg::MODE_CMP_SET) begin
            d.pin = 1'b1;
          end else if (mode == ccp_pkg::MODE_CMP_CLR) begin
            d.pin = 1'b0;
          end else if (mode == ccp_pkg::MODE_CMP_SPECIAL) begin
            d.tmr_reset = 1'b1;
            d.adc_go = adc_enabled;
          end
        end
      end
      ccp_pkg::ST_PWM: begin
        if (timebase_two_period) begin
          // Duty is latched once a period to avoid glitched pulses
          d.duty = {q.value[7:0], q.ctrl[ccp_pkg::CTRL_LSB_ONE_POS],
                    q.ctrl[ccp_pkg::CTRL_LSB_ZERO_POS]};
          d.pin = d.duty != 10'h000;
          period_ev = 1'b1;
        end else if (timebase_two_count >= q.duty) begin
          d.pin = 1'b0;
        end
      end
      default: d.pin = 1'b0;
    endcase

    // Set wins over a clear in the same cycle
    d.status[ccp_pkg::EV_UNIT] = d.status[ccp_pkg::EV_UNIT] | unit_ev;
    d.status[ccp_pkg::EV_PERIOD] = d.status[ccp_pkg::EV_PERIOD] | period_ev;

    if (mode == ccp_pkg::MODE_OFF) begin
      d.state = ccp_pkg::ST_OFF;
    end else if (mode[3:2] == 2'b11) begin
      d.state = ccp_pkg::ST_PWM;
    end else if (mode[3]) begin
      d.state = ccp_pkg::ST_COMPARE;
    end else if (mode[2]) begin
      d.state = ccp_pkg::ST_CAPTURE;
    end else begin
      // Codes 0001 to 0011 are unused; treat them as off
      d.state = ccp_pkg::ST_OFF;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q.state <= ccp_pkg::ST_OFF;
      q.ctrl <= ccp_pkg::CTRL_RESET;
      q.value <= ccp_pkg::VALUE_RESET;
      q.status <= ccp_pkg::EV_RESET;
      q.irq_en <= ccp_pkg::EV_RESET;
      q.pin <= 1'b0;
      q.pin_prev <= 1'b0;
      q.match_prev <= 1'b0;
      q.duty <= 10'h000;
      q.tmr_reset <= 1'b0;
      q.adc_go <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Read side; write-only clear register reads zero
  always_comb begin
    unique case (rif.rd_idx)
      ccp_pkg::IDX_VALUE_LOW: rif.rdata = q.value[7:0];
      ccp_pkg::IDX_VALUE_HIGH: rif.rdata = q.value[15:8];
      ccp_pkg::IDX_CONTROL: rif.rdata = {2'b00, q.ctrl};
      ccp_pkg::IDX_STATUS: rif.rdata = {6'h00, q.status};
      ccp_pkg::IDX_IRQ_ENABLE: rif.rdata = {6'h00, q.irq_en};
      default: rif.rdata = 8'h00;
    endcase
  end

  // Capture leaves the pin as input; compare and PWM drive it
  assign drive = (q.state == ccp_pkg::ST_COMPARE) |
                 (q.state == ccp_pkg::ST_PWM);
  assign port_b_pin_two_out = q.pin;
  assign port_b_pin_three_out = q.pin;
  assign port_b_pin_two_oe = drive & !pin_route_select;
  assign port_b_pin_three_oe = drive & pin_route_select;
  assign timebase_one_reset = q.tmr_reset;
  assign adc_start = q.adc_go;
  assign irq = |(q.status & q.irq_en);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_special_hit;
    q.state == ccp_pkg::ST_COMPARE && mode == ccp_pkg::MODE_CMP_SPECIAL
      && hit;
  endsequence

  sequence s_off_held;
    (mode == ccp_pkg::MODE_OFF) [*2];
  endsequence

  property p_special_reset;
    s_special_hit |=> timebase_one_reset ##1 !timebase_one_reset;
  endproperty
  a_special_reset: assert property (p_special_reset)
    else $error("special event did not pulse timebase reset");

  property p_adc_gate;
    adc_start |-> $past(adc_enabled) && !$past(timebase_one_reset)
      && timebase_one_reset;
  endproperty
  a_adc_gate: assert property (p_adc_gate)
    else $error("conversion start without enable or timer reset");

  property p_special_flag;
    s_special_hit |=> q.status[ccp_pkg::EV_UNIT] && $stable(q.pin);
  endproperty
  a_special_flag: assert property (p_special_flag)
    else $error("special event flag or pin wrong");

  property p_route;
    pin_route_select ? !port_b_pin_two_oe : !port_b_pin_three_oe;
  endproperty
  a_route: assert property (p_route)
    else $error("unit pin driven on unrouted port pin");

  property p_off_quiet;
    s_off_held |=> q.duty == 10'h000 && !q.pin && !port_b_pin_two_oe
      && !port_b_pin_three_oe;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled unit kept state or drove pin");

  property p_duty_load;
    q.state == ccp_pkg::ST_PWM && timebase_two_period |=>
      q.duty[9:2] == $past(q.value[7:0])
      && q.duty[1:0] == $past(q.ctrl[5:4]);
  endproperty
  a_duty_load: assert property (p_duty_load)
    else $error("duty latch does not join low byte and lsbs");

  property p_ctrl_write;
    rif.wr && rif.idx == ccp_pkg::IDX_CONTROL |=>
      q.ctrl == $past(rif.wdata[5:0]) ##1 q.state != ccp_pkg::ST_OFF
      || q.ctrl[3:0] == ccp_pkg::MODE_OFF || q.ctrl[3:2] == 2'b00;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not taken or mode not applied");

  property p_capture;
    q.state == ccp_pkg::ST_CAPTURE && capture_edge |=>
      q.value == $past(timebase_one_counter) && q.status[ccp_pkg::EV_UNIT];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not load timebase one");

  property p_low_write;
    rif.wr && rif.idx == ccp_pkg::IDX_VALUE_LOW
      && q.state != ccp_pkg::ST_CAPTURE |=>
      q.value[7:0] == $past(rif.wdata) && $stable(q.value[15:8]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low byte write lost or touched high byte");

  property p_pwm_mode;
    mode[3:2] == 2'b11 |=> q.state == ccp_pkg::ST_PWM;
  endproperty
  a_pwm_mode: assert property (p_pwm_mode)
    else $error("11xx mode did not select pwm");

  property p_cmp_set;
    q.state == ccp_pkg::ST_COMPARE && mode == ccp_pkg::MODE_CMP_SET && hit
      |=> q.pin;
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("compare set mode did not raise the pin");

  property p_cmp_clr;
    q.state == ccp_pkg::ST_COMPARE && mode == ccp_pkg::MODE_CMP_CLR && hit
      |=> !q.pin;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr)
    else $error("compare clear mode did not lower the pin");

  property p_special_noadc;
    s_special_hit ##0 !adc_enabled |=> !adc_start;
  endproperty
  a_special_noadc: assert property (p_special_noadc)
    else $error("conversion started while converter was off");

  property p_high_write;
    rif.wr && rif.idx == ccp_pkg::IDX_VALUE_HIGH
      && q.state != ccp_pkg::ST_CAPTURE |=>
      q.value[15:8] == $past(rif.wdata) && $stable(q.value[7:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high byte write lost or touched low byte");

  property p_pwm_drop;
    q.state == ccp_pkg::ST_PWM && !timebase_two_period
      && timebase_two_count >= q.duty |=> !q.pin;
  endproperty
  a_pwm_drop: assert property (p_pwm_drop)
    else $error("pwm pin did not fall at the duty count");

  property p_period_flag;
    q.state == ccp_pkg::ST_PWM && timebase_two_period
      |=> q.status[ccp_pkg::EV_PERIOD];
  endproperty
  a_period_flag: assert property (p_period_flag)
    else $error("pwm period end did not set its flag");

  property p_duty_hold;
    q.state == ccp_pkg::ST_PWM && !timebase_two_period |=> $stable(q.duty);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed inside a pwm period");

  property p_off_events;
    q.state == ccp_pkg::ST_OFF |=> !timebase_one_reset && !adc_start;
  endproperty
  a_off_events: assert property (p_off_events)
    else $error("disabled unit pulsed timer reset or conversion");

  property p_mode_compare;
    mode[3:2] == 2'b10 |=> q.state == ccp_pkg::ST_COMPARE;
  endproperty
  a_mode_compare: assert property (p_mode_compare)
    else $error("10xx mode did not select compare");

  property p_mode_capture;
    mode[3:2] == 2'b01 |=> q.state == ccp_pkg::ST_CAPTURE;
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("01xx mode did not select capture");

endmodule

// [design/ccp_pkg.sv]
package ccp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
  localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
  localparam logic [7:0] IDX_CONTROL = 8'h17;
  localparam logic [7:0] IDX_STATUS = 8'h18;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1a;
  localparam logic [7:0] IDX_NONE = 8'hff;

  // Control register layout
  localparam int CTRL_WIDTH = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_LSB_ZERO_POS = 4;
  localparam int CTRL_LSB_ONE_POS = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // Status, enable and clear share this layout
  localparam int NUM_EVENTS = 2;
  localparam int EV_UNIT = 0;
  localparam int EV_PERIOD = 1;
  localparam logic [1:0] EV_RESET = 2'h0;

  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_IRQ = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_CAPTURE = 4'b0010,
    ST_COMPARE = 4'b0100,
    ST_PWM = 4'b1000
  } unit_state_t;

endpackage

// [design/ccp_reg_if.sv]
`timescale 1ns/1ps
interface ccp_reg_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic rd;
  logic [7:0] rd_idx;
  logic [7:0] rdata;
  modport bus_side(output wr, idx, wdata, rd, rd_idx, input rdata);
  modport core_side(input wr, idx, wdata, rd, rd_idx, output rdata);
endinterface

// [design/ccp_ahb_port.sv]
`timescale 1ns/1ps
module ccp_ahb_port (
  input wire logic mclk, // Core clock
  input wire logic rstn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  ccp_reg_if.bus_side rif // Register strobes
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rdata;
  } port_t;

  port_t q, d;
  logic accept;
  logic [7:0] idx;

  always_comb begin
    accept = hsel & htrans[1] & hready;
    idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : ccp_pkg::IDX_NONE;
    d = q;
    d.wr_pend = accept & hwrite;
    d.wr_idx = idx;
    // Read data is caught at the address phase, so no wait state
    if (accept && !hwrite) begin
      d.rdata = rif.rdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rif.wr = q.wr_pend;
  assign rif.idx = q.wr_idx;
  assign rif.wdata = hwdata[7:0];
  assign rif.rd = accept & !hwrite;
  assign rif.rd_idx = idx;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, q.rdata};

  property p_ctrl_upper_zero;
    @(posedge mclk) disable iff (!rstn)
    rif.rd && rif.rd_idx == ccp_pkg::IDX_CONTROL |=> hrdata[7:6] == 2'b00;
  endproperty
  a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
    else $error("control bits 7:6 read nonzero");

endmodule

// [testbench/ccp_far_side.sv]
`timescale 1ns/1ps
module ccp_far_side (
  input wire logic mclk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic timebase_one_reset, // Clear pulse from unit
  output logic [15:0] timebase_one_counter, // Free running count
  output logic [9:0] timebase_two_count, // PWM count
  output logic timebase_two_period // Period end pulse
);
  // Both timebases free run so match points recur without software help
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timebase_one_counter <= 16'h0000;
      timebase_two_count <= 10'h000;
    end else begin
      if (timebase_one_reset)
        timebase_one_counter <= 16'h0000;
      else
        timebase_one_counter <= timebase_one_counter + 16'h0001;
      timebase_two_count <= timebase_two_count + 10'h001;
    end
  end
  assign timebase_two_period = (timebase_two_count == 10'h3ff);
endmodule

// [testbench/test_ccp_unit.sv]
`timescale 1ns/1ps
module test_ccp_unit;
  logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [15:0] tb1;
  logic [9:0] tb2;
  logic tb1_rst, adc_en, adc_start, per, route, p2_in, p3_in;
  logic p2_out, p2_oe, p3_out, p3_oe;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] rv;

  ccp_unit i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .timebase_one_counter(tb1), .timebase_one_reset(tb1_rst),
    .adc_enabled(adc_en), .adc_start(adc_start), .timebase_two_count(tb2),
    .timebase_two_period(per), .pin_route_select(route),
    .port_b_pin_two_in(p2_in), .port_b_pin_two_out(p2_out),
    .port_b_pin_two_oe(p2_oe), .port_b_pin_three_in(p3_in),
    .port_b_pin_three_out(p3_out), .port_b_pin_three_oe(p3_oe), .irq(irq));
  ccp_far_side i_far (.mclk(mclk), .rstn(rstn), .timebase_one_reset(tb1_rst),
    .timebase_one_counter(tb1), .timebase_two_count(tb2),
    .timebase_two_period(per));
  assign hready = hreadyout;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; the wait ends only on ready, never on a count
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    xfer(1'b1, idx, wd, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk("register", {8'h00, exp}, {8'h00, d});
  endtask

  task automatic t_regs;
    rdchk(ccp_pkg::IDX_CONTROL, 8'h00);
    rdchk(ccp_pkg::IDX_VALUE_LOW, 8'h00);
    wr(ccp_pkg::IDX_CONTROL, 8'hf0);
    rdchk(ccp_pkg::IDX_CONTROL, 8'h30);
    wr(ccp_pkg::IDX_CONTROL, 8'h00);
    wr(ccp_pkg::IDX_VALUE_LOW, 8'ha5);
    wr(ccp_pkg::IDX_VALUE_HIGH, 8'h5a);
    rdchk(ccp_pkg::IDX_VALUE_LOW, 8'ha5);
    rdchk(ccp_pkg::IDX_VALUE_HIGH, 8'h5a);
    rdchk(8'h20, 8'h00);
    $display("test regs done");
  endtask

  // Waits for the reset pulse, then judges the start pulse in that cycle
  task automatic t_special;
    wr(ccp_pkg::IDX_VALUE_LOW, 8'h40);
    wr(ccp_pkg::IDX_VALUE_HIGH, 8'h00);
    wr(ccp_pkg::IDX_IRQ_ENABLE, 8'h01);
    wr(ccp_pkg::IDX_CONTROL, 8'h0b);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk);
      while (tb1_rst !== 1'b1) @(negedge mclk);
      chk("adc_start", {15'h0, ~k[0]}, {15'h0, adc_start});
      chk("pin", 16'h0000, {15'h0, p2_out});
      @(posedge mclk);
      rdchk(ccp_pkg::IDX_STATUS, 8'h01);
      chk("irq", 16'h0001, {15'h0, irq});
      wr(ccp_pkg::IDX_IRQ_CLEAR, 8'h01);
      rdchk(ccp_pkg::IDX_STATUS, 8'h00);
      chk("irq", 16'h0000, {15'h0, irq});
      adc_en <= 1'b0;
    end
    $display("test special done");
  endtask

  task automatic t_route;
    wr(ccp_pkg::IDX_CONTROL, 8'h00);
    wr(ccp_pkg::IDX_VALUE_LOW, 8'hf0);
    wr(ccp_pkg::IDX_CONTROL, 8'h08);
    // The mode takes effect one cycle after the control write
    @(posedge mclk);
    @(negedge mclk);
    chk("oe", 16'h0010, {11'h0, p2_oe, 3'h0, p3_oe});
    @(posedge mclk);
    route <= 1'b1;
    @(negedge mclk);
    chk("oe", 16'h0001, {11'h0, p2_oe, 3'h0, p3_oe});
    while (tb1 !== 16'h00f3) @(negedge mclk);
    chk("pin", 16'h0001, {15'h0, p3_out});
    // Clear mode keeps the pin high until the next match at 01f0h
    wr(ccp_pkg::IDX_VALUE_HIGH, 8'h01);
    wr(ccp_pkg::IDX_CONTROL, 8'h09);
    while (tb1 !== 16'h01ef) @(negedge mclk);
    chk("pin", 16'h0001, {15'h0, p3_out});
    while (tb1 !== 16'h01f3) @(negedge mclk);
    chk("pin", 16'h0000, {15'h0, p3_out});
    rdchk(ccp_pkg::IDX_STATUS, 8'h01);
    wr(ccp_pkg::IDX_IRQ_CLEAR, 8'h01);
    wr(ccp_pkg::IDX_CONTROL, 8'h00);
    // State goes off one edge later, the pin one edge after that
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("off", 16'h0000, {14'h0, p3_oe, p3_out});
    @(posedge mclk);
    route <= 1'b0;
    $display("test route done");
  endtask

  // Rising edge on pin two loads the timebase one count seen that cycle
  task automatic t_capture;
    logic [15:0] cap;
    wr(ccp_pkg::IDX_CONTROL, 8'h04);
    repeat (2) @(posedge mclk);
    p2_in <= 1'b1;
    @(negedge mclk);
    cap = tb1;
    @(posedge mclk);
    p2_in <= 1'b0;
    rdchk(ccp_pkg::IDX_VALUE_LOW, cap[7:0]);
    rdchk(ccp_pkg::IDX_VALUE_HIGH, cap[15:8]);
    rdchk(ccp_pkg::IDX_STATUS, 8'h01);
    wr(ccp_pkg::IDX_IRQ_CLEAR, 8'h01);
    wr(ccp_pkg::IDX_CONTROL, 8'h00);
    $display("test capture done");
  endtask

  // Duty 203h: the pin falls between counts 203h and 204h only if
  // both low bits land; a missing bit zero makes it fall a count early, a missing bit one two counts early
  task automatic t_pwm;
    wr(ccp_pkg::IDX_VALUE_LOW, 8'h80);
    wr(ccp_pkg::IDX_CONTROL, 8'h3f);
    @(posedge mclk);
    @(negedge mclk);
    while (per !== 1'b1) @(negedge mclk);
    while (tb2 !== 10'h203) @(negedge mclk);
    chk("pwm", 16'h0001, {15'h0, p2_out});
    while (tb2 !== 10'h204) @(negedge mclk);
    chk("pwm", 16'h0000, {15'h0, p2_out});
    rdchk(ccp_pkg::IDX_STATUS, 8'h02);
    $display("test pwm done");
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    adc_en = 1'b1;
    route = 1'b0;
    p2_in = 1'b0;
    p3_in = 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_special();
    t_route();
    t_capture();
    t_pwm();
    end_sim();
  end
endmodule
